// ---- spc_axi_slave.sv ----
/*
  axi4-lite slave for the single serial port control word.
  assumes one clock, synchronous active-low reset; unmapped words answer slverr.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_axi_slave (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  spc_bus_if.slave bus
);
  logic aw_ff, w_ff;
  logic [11:0] awa_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;

  function automatic logic hit(input logic [11:0] a);
    hit = (a[11:2] == spc_pkg::SPC_CTL_OFFSET[11:2]);
  endfunction

  // address and data latch independently, either order
  assign awready = !aw_ff && !bvalid;
  assign wready = !w_ff && !bvalid;
  assign arready = !rvalid;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 12'h000;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
    end else if (aw_ff && w_ff) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_ff <= 1'b1;
        awa_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_ff <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
    end
  end

  // write strobe in the cycle both halves are held
  assign bus.wr_stb = aw_ff && w_ff && hit(awa_ff);
  assign bus.wr_data = wd_ff;
  assign bus.wr_strb = ws_ff;

  // write response
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= spc_pkg::SPC_RESP_OKAY;
    end else if (aw_ff && w_ff) begin
      bvalid <= 1'b1;
      bresp <= hit(awa_ff) ? spc_pkg::SPC_RESP_OKAY : spc_pkg::SPC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read answered one cycle after acceptance
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= spc_pkg::SPC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= hit(araddr) ? bus.rd_data : 32'h0000_0000;
      rresp <= hit(araddr) ? spc_pkg::SPC_RESP_OKAY : spc_pkg::SPC_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- spc_bus_if.sv ----
/*
  interface carrying one register write and the read-back word between the
  axi slave and the serial port control core.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface spc_bus_if;
  logic wr_stb;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_data;
  modport core (input wr_stb, input wr_data, input wr_strb, output rd_data);
  modport slave (output wr_stb, output wr_data, output wr_strb, input rd_data);
endinterface
`default_nettype wire

// ---- spc_link_model.sv ----
/*
  spc_link_model: behavioural link trainer standing for the adjacent partner.
  assumes the block's clock and reset; reports a width once per training.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_link_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic retrain,
  input wire logic slow,
  input wire logic degrade,
  input wire logic [2:0] ovr,
  output logic done,
  output logic [2:0] width
);
  logic [4:0] cnt_ff;
  logic [2:0] tgt_ff;
  // width is only qualified by done, so it toggles to expose stale sampling
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_ff <= 5'h3;
      tgt_ff <= spc_pkg::SPC_TW_4X;
      done <= 1'b0;
      width <= 3'h0;
    end else begin
      done <= 1'b0;
      width <= ~width;
      if (retrain) begin
        cnt_ff <= slow ? 5'h18 : 5'h3;
        tgt_ff <= (ovr == spc_pkg::SPC_OVR_L0) ? spc_pkg::SPC_TW_1X_L0 :
                  (ovr == spc_pkg::SPC_OVR_L2) ? spc_pkg::SPC_TW_1X_L2 : spc_pkg::SPC_TW_4X;
      end else if (degrade) begin
        done <= 1'b1;
        width <= spc_pkg::SPC_TW_1X_L2;
      end else if (cnt_ff == 5'h1) begin
        done <= 1'b1;
        width <= tgt_ff;
        cnt_ff <= 5'h0;
      end else if (cnt_ff != 5'h0) begin
        cnt_ff <= cnt_ff - 5'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- spc_pkg.sv ----
/*
  package for the serial port control register block: offsets, bit positions,
  encodings and reset values.
  assumes a single 250 MHz clock domain and an AXI4-Lite master outside.
*/
// Operation
// - powered-down port reads fixed 0x0000001
// - capability field shows strapped mode, 00/01
// - pin high: even and odd capability 0
// - pin low: even 1, odd 0, odd unusable
// - trained width updates on init and change
// - trained width codes 000, 001, 010
// - override codes 000, 010, 011; rest reserved
// - changed override write forces link retrain
// - override loadable at power-up or runtime
// - pin sampled at reset release only
// - shutdown bit disables receivers and drivers
// - shut-down drivers output zeros only
// - packets for shut-down port stay queued
// - egress allow 0: maintenance only; resets 1
// - ingress allow 0: nonmaintenance gets not-accepted
// - ingress allow 1 accepts everything; resets 1
package spc_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [11:0] SPC_CTL_OFFSET = 12'h15c;
  localparam logic [31:0] SPC_POWERDOWN_VALUE = 32'h0000_0001;

  // -----------------------------------------------------------------
  // field positions, expressed as lsb-0 indices (msb-0 bit n = 31-n)
  // -----------------------------------------------------------------
  localparam int SPC_CAP_HI = 31;       // msb-0 bits 0:1
  localparam int SPC_CAP_LO = 30;
  localparam int SPC_TW_HI = 29;        // msb-0 bits 2:4
  localparam int SPC_TW_LO = 27;
  localparam int SPC_OVR_HI = 26;       // msb-0 bits 5:7
  localparam int SPC_OVR_LO = 24;
  localparam int SPC_SHUT_BIT = 23;     // msb-0 bit 8
  localparam int SPC_EGR_BIT = 22;      // msb-0 bit 9
  localparam int SPC_INGR_BIT = 21;     // msb-0 bit 10

  // -----------------------------------------------------------------
  // encodings and reset values
  // -----------------------------------------------------------------
  localparam logic [1:0] SPC_CAP_1X_ONLY = 2'h0;
  localparam logic [1:0] SPC_CAP_4X = 2'h1;
  localparam logic [2:0] SPC_TW_1X_L0 = 3'h0;
  localparam logic [2:0] SPC_TW_1X_L2 = 3'h1;
  localparam logic [2:0] SPC_TW_4X = 3'h2;
  localparam logic [2:0] SPC_OVR_NONE = 3'h0;
  localparam logic [2:0] SPC_OVR_L0 = 3'h2;
  localparam logic [2:0] SPC_OVR_L2 = 3'h3;
  localparam logic SPC_SHUT_RST = 1'b0;
  localparam logic SPC_EGR_RST = 1'b1;
  localparam logic SPC_INGR_RST = 1'b1;
  localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;

endpackage

// ---- spc_port_ctrl.sv ----
/*
  serial port control register of one switch port: strapped capability,
  trained width, width override with retrain, shutdown and traffic gates.
  assumes the link trainer, egress and ingress logic sit outside on CLK.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_port_ctrl (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic IS_ODD_PORT,
  input wire logic LANE_CONFIG_PIN,
  input wire logic [2:0] PWRUP_OVERRIDE,
  input wire logic POWERED_DOWN,
  input wire logic TRAIN_DONE,
  input wire logic [2:0] TRAIN_WIDTH,
  output logic FORCED_RETRAIN,
  output logic [2:0] OVERRIDE_WIDTH,
  output logic ODD_PORT_DISABLE,
  output logic PORT_SHUTDOWN,
  input wire logic [3:0] TX_LANE_DATA_IN,
  output logic [3:0] TX_LANE_DATA,
  output logic RX_ENABLE,
  input wire logic EGR_PKT_VALID,
  input wire logic EGR_PKT_MAINT,
  output logic EGR_PKT_ISSUE,
  output logic EGR_PKT_HOLD,
  input wire logic ING_PKT_VALID,
  input wire logic ING_PKT_MAINT,
  output logic ING_PKT_ACCEPT,
  output logic ING_PKT_NOT_ACCEPTED
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  spc_bus_if bus ();
  logic [2:0] pin_sync_ff;
  logic [2:0] sync_fill_ff;
  logic strap_done_ff;
  logic [1:0] cap_ff;
  logic [2:0] tw_ff;
  logic [2:0] ovr_ff;
  logic shut_ff;
  logic egr_ff;
  logic ingr_ff;
  logic retrain_ff;
  logic [2:0] nxt_ovr;
  logic [31:0] live_word;

  // -----------------------------------------------------------------
  // bus slave
  // -----------------------------------------------------------------
  spc_axi_slave u_slave (
    .clk(CLK),
    .rstn(RSTN),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .bus(bus.slave)
  );

  // -----------------------------------------------------------------
  // strap capture
  // -----------------------------------------------------------------
  // pin is asynchronous: three stages, accept when last two agree
  // fill marker: the reset zeros in the stages would agree at once and fake a low strap
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pin_sync_ff <= 3'h0;
      sync_fill_ff <= 3'h0;
    end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], LANE_CONFIG_PIN};
      sync_fill_ff <= {sync_fill_ff[1:0], 1'b1};
    end
  end

  // capability caught once after reset release, then frozen
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      strap_done_ff <= 1'b0;
      cap_ff <= spc_pkg::SPC_CAP_1X_ONLY;
    end else if (!strap_done_ff && sync_fill_ff[2] &&
                 (pin_sync_ff[1] == pin_sync_ff[2])) begin
      strap_done_ff <= 1'b1;
      if (pin_sync_ff[2] || IS_ODD_PORT) begin
        cap_ff <= spc_pkg::SPC_CAP_1X_ONLY;
      end else begin
        cap_ff <= spc_pkg::SPC_CAP_4X;
      end
    end
  end

  // odd partner unusable whenever the even port is strapped 4x or trained 4x
  assign ODD_PORT_DISABLE = strap_done_ff && !IS_ODD_PORT &&
                            (cap_ff == spc_pkg::SPC_CAP_4X ||
                             tw_ff == spc_pkg::SPC_TW_4X);

  // -----------------------------------------------------------------
  // trained width
  // -----------------------------------------------------------------
  // follow the trainer on completion and on every later width change
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      tw_ff <= spc_pkg::SPC_TW_1X_L0;
    end else if (TRAIN_DONE) begin
      case (TRAIN_WIDTH)
        spc_pkg::SPC_TW_1X_L0, spc_pkg::SPC_TW_1X_L2, spc_pkg::SPC_TW_4X: begin
          tw_ff <= TRAIN_WIDTH;
        end
        default: begin
          tw_ff <= tw_ff;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // width override and retrain
  // -----------------------------------------------------------------
  // byte lane 3 holds override; reserved codes leave it unchanged
  always_comb begin
    nxt_ovr = ovr_ff;
    if (bus.wr_stb && bus.wr_strb[3]) begin
      case (bus.wr_data[spc_pkg::SPC_OVR_HI:spc_pkg::SPC_OVR_LO])
        spc_pkg::SPC_OVR_NONE, spc_pkg::SPC_OVR_L0, spc_pkg::SPC_OVR_L2: begin
          nxt_ovr = bus.wr_data[spc_pkg::SPC_OVR_HI:spc_pkg::SPC_OVR_LO];
        end
        default: begin
          nxt_ovr = ovr_ff;
        end
      endcase
    end
  end

  // power-up load repeats every cycle after release until the strap is caught
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ovr_ff <= spc_pkg::SPC_OVR_NONE;
      retrain_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      ovr_ff <= (PWRUP_OVERRIDE == spc_pkg::SPC_OVR_L0 ||
                 PWRUP_OVERRIDE == spc_pkg::SPC_OVR_L2) ?
                PWRUP_OVERRIDE : spc_pkg::SPC_OVR_NONE;
      retrain_ff <= 1'b0;
    end else begin
      ovr_ff <= nxt_ovr;
      retrain_ff <= (nxt_ovr != ovr_ff);
    end
  end

  assign FORCED_RETRAIN = retrain_ff;
  // override only reaches the trainer on a four-lane port running 4x
  assign OVERRIDE_WIDTH = (cap_ff == spc_pkg::SPC_CAP_4X && tw_ff == spc_pkg::SPC_TW_4X) ?
                          ovr_ff : spc_pkg::SPC_OVR_NONE;

  // -----------------------------------------------------------------
  // shutdown and traffic gates
  // -----------------------------------------------------------------
  // byte lane 2 holds the three control bits
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      shut_ff <= spc_pkg::SPC_SHUT_RST;
      egr_ff <= spc_pkg::SPC_EGR_RST;
      ingr_ff <= spc_pkg::SPC_INGR_RST;
    end else if (bus.wr_stb && bus.wr_strb[2]) begin
      shut_ff <= bus.wr_data[spc_pkg::SPC_SHUT_BIT];
      egr_ff <= bus.wr_data[spc_pkg::SPC_EGR_BIT];
      ingr_ff <= bus.wr_data[spc_pkg::SPC_INGR_BIT];
    end
  end

  assign PORT_SHUTDOWN = shut_ff;
  assign RX_ENABLE = !shut_ff;

  // drivers forced to zero from a flop, starting one cycle after shutdown sets
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      TX_LANE_DATA <= 4'h0;
    end else begin
      TX_LANE_DATA <= shut_ff ? 4'h0 : TX_LANE_DATA_IN;
    end
  end

  // egress: hold, never drop, so queued packets survive shutdown
  assign EGR_PKT_ISSUE = EGR_PKT_VALID && !shut_ff &&
                         (egr_ff || EGR_PKT_MAINT);
  assign EGR_PKT_HOLD = EGR_PKT_VALID && !EGR_PKT_ISSUE;

  // ingress: reject non-maintenance when gated; nothing while shut down
  assign ING_PKT_ACCEPT = ING_PKT_VALID && !shut_ff &&
                          (ingr_ff || ING_PKT_MAINT);
  assign ING_PKT_NOT_ACCEPTED = ING_PKT_VALID && !shut_ff &&
                                !ingr_ff && !ING_PKT_MAINT;

  // -----------------------------------------------------------------
  // read-back
  // -----------------------------------------------------------------
  // msb-0 numbering: fields packed from the top, reserved bits zero
  always_comb begin
    live_word = 32'h0000_0000;
    live_word[spc_pkg::SPC_CAP_HI:spc_pkg::SPC_CAP_LO] = cap_ff;
    live_word[spc_pkg::SPC_TW_HI:spc_pkg::SPC_TW_LO] = tw_ff;
    live_word[spc_pkg::SPC_OVR_HI:spc_pkg::SPC_OVR_LO] = ovr_ff;
    live_word[spc_pkg::SPC_SHUT_BIT] = shut_ff;
    live_word[spc_pkg::SPC_EGR_BIT] = egr_ff;
    live_word[spc_pkg::SPC_INGR_BIT] = ingr_ff;
  end

  assign bus.rd_data = POWERED_DOWN ? spc_pkg::SPC_POWERDOWN_VALUE : live_word;

endmodule
`default_nettype wire

// ---- spc_port_ctrl_properties.sv ----
/*
  spc_port_ctrl_chk: concurrent checks on the top ports of spc_port_ctrl.
  assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module spc_port_ctrl_chk (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic POWERED_DOWN,
  input wire logic IS_ODD_PORT,
  input wire logic FORCED_RETRAIN,
  input wire logic PORT_SHUTDOWN,
  input wire logic RX_ENABLE,
  input wire logic [3:0] TX_LANE_DATA,
  input wire logic EGR_PKT_VALID,
  input wire logic EGR_PKT_MAINT,
  input wire logic EGR_PKT_ISSUE,
  input wire logic EGR_PKT_HOLD,
  input wire logic ING_PKT_VALID,
  input wire logic ING_PKT_MAINT,
  input wire logic ING_PKT_ACCEPT,
  input wire logic ING_PKT_NOT_ACCEPTED,
  input wire logic ODD_PORT_DISABLE
);
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // live words only; the powered-down word is fixed and skipped
  sequence s_live;
    RVALID && RRESP == spc_pkg::SPC_RESP_OKAY && RDATA != spc_pkg::SPC_POWERDOWN_VALUE;
  endsequence
  property p_pwrdn;
    ARVALID && ARREADY && POWERED_DOWN && ARADDR == spc_pkg::SPC_CTL_OFFSET
      |=> RDATA == spc_pkg::SPC_POWERDOWN_VALUE;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("powered-down word wrong");
  property p_rsv;
    s_live |-> RDATA[20:0] == 21'h0_0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_cap_odd;
    s_live |-> !IS_ODD_PORT || RDATA[31:30] == spc_pkg::SPC_CAP_1X_ONLY;
  endproperty
  a_cap_odd: assert property (p_cap_odd) else $error("odd port capability");
  property p_shut;
    PORT_SHUTDOWN |-> !RX_ENABLE && !ING_PKT_ACCEPT && !ING_PKT_NOT_ACCEPTED;
  endproperty
  a_shut: assert property (p_shut) else $error("receiver active in shutdown");
  property p_tx_zero;
    PORT_SHUTDOWN [*2] |-> TX_LANE_DATA == 4'h0;
  endproperty
  a_tx_zero: assert property (p_tx_zero) else $error("lanes not zero");
  property p_egr_hold;
    EGR_PKT_VALID && PORT_SHUTDOWN |-> EGR_PKT_HOLD && !EGR_PKT_ISSUE;
  endproperty
  a_egr_hold: assert property (p_egr_hold) else $error("egress not held");
  property p_egr_maint;
    EGR_PKT_VALID && EGR_PKT_MAINT && !PORT_SHUTDOWN |-> EGR_PKT_ISSUE;
  endproperty
  a_egr_maint: assert property (p_egr_maint) else $error("maintenance not issued");
  property p_ing_maint;
    ING_PKT_VALID && ING_PKT_MAINT && !PORT_SHUTDOWN |-> ING_PKT_ACCEPT;
  endproperty
  a_ing_maint: assert property (p_ing_maint) else $error("maintenance refused");
  property p_ing_nac;
    ING_PKT_NOT_ACCEPTED |-> ING_PKT_VALID && !ING_PKT_MAINT && !ING_PKT_ACCEPT;
  endproperty
  a_ing_nac: assert property (p_ing_nac) else $error("bad not-accepted");
  property p_retrain;
    FORCED_RETRAIN |=> !FORCED_RETRAIN;
  endproperty
  a_retrain: assert property (p_retrain) else $error("retrain not a pulse");
  property p_odd;
    IS_ODD_PORT |-> !ODD_PORT_DISABLE;
  endproperty
  a_odd: assert property (p_odd) else $error("odd port disables itself");
  c_retrain: cover property (FORCED_RETRAIN);
  c_hold: cover property (EGR_PKT_HOLD && PORT_SHUTDOWN);
  c_nac: cover property (ING_PKT_NOT_ACCEPTED);
endmodule
bind spc_port_ctrl spc_port_ctrl_chk u_chk (.CLK(CLK), .RSTN(RSTN), .ARADDR(ARADDR),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .POWERED_DOWN(POWERED_DOWN), .IS_ODD_PORT(IS_ODD_PORT), .FORCED_RETRAIN(FORCED_RETRAIN),
  .PORT_SHUTDOWN(PORT_SHUTDOWN), .RX_ENABLE(RX_ENABLE), .TX_LANE_DATA(TX_LANE_DATA),
  .EGR_PKT_VALID(EGR_PKT_VALID), .EGR_PKT_MAINT(EGR_PKT_MAINT), .EGR_PKT_ISSUE(EGR_PKT_ISSUE),
  .EGR_PKT_HOLD(EGR_PKT_HOLD), .ING_PKT_VALID(ING_PKT_VALID), .ING_PKT_MAINT(ING_PKT_MAINT),
  .ING_PKT_ACCEPT(ING_PKT_ACCEPT), .ING_PKT_NOT_ACCEPTED(ING_PKT_NOT_ACCEPTED),
  .ODD_PORT_DISABLE(ODD_PORT_DISABLE));
`default_nettype wire

// ---- tb.sv ----
/*
  tb: self-checking bench for spc_port_ctrl beside the link model.
  assumes the 250 MHz clock and an axi4-lite master driven here.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  // -----------------------------------------------------------------
  // signals and counters
  // -----------------------------------------------------------------
  logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic odd = 0, pin = 0, pdown = 0, egr_v = 0, egr_m = 0, ing_v = 0, ing_m = 0;
  logic slow = 0, degrade = 0, sh, eg, ig, t_done;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, r, seed = 32'h0000_61da;
  logic [3:0] wstrb = 0, tx_in = 0, prev, tx;
  logic [2:0] pwo = 0, ovr_w, tw;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, retrain, odd_dis, shut, rx_en;
  logic e_iss, e_hold, i_acc, i_nac;
  logic [31:0] rdata;
  int err_count = 0, n_compared = 0, n_retrain = 0;
  always #2 clk = ~clk;
  // retrain pulses seen at the link, counted for the override scenarios
  always @(posedge clk) begin
    if (retrain === 1'b1) begin
      n_retrain <= n_retrain + 1;
    end
  end
  spc_port_ctrl dut (.CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .IS_ODD_PORT(odd), .LANE_CONFIG_PIN(pin), .PWRUP_OVERRIDE(pwo), .POWERED_DOWN(pdown),
    .TRAIN_DONE(t_done), .TRAIN_WIDTH(tw), .FORCED_RETRAIN(retrain), .OVERRIDE_WIDTH(ovr_w),
    .ODD_PORT_DISABLE(odd_dis), .PORT_SHUTDOWN(shut), .TX_LANE_DATA_IN(tx_in),
    .TX_LANE_DATA(tx), .RX_ENABLE(rx_en), .EGR_PKT_VALID(egr_v), .EGR_PKT_MAINT(egr_m),
    .EGR_PKT_ISSUE(e_iss), .EGR_PKT_HOLD(e_hold), .ING_PKT_VALID(ing_v),
    .ING_PKT_MAINT(ing_m), .ING_PKT_ACCEPT(i_acc), .ING_PKT_NOT_ACCEPTED(i_nac));
  spc_link_model u_link (.clk(clk), .rstn(rstn), .retrain(retrain), .slow(slow),
    .degrade(degrade), .ovr(ovr_w), .done(t_done), .width(tw));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] word(input logic [1:0] c, input logic [2:0] t, o,
                                       input logic s, e, i);
    return {c, t, o, s, e, i, 21'h0_0000};
  endfunction
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected gate outputs worked out from the shutdown and allow bits
  function automatic logic [1:0] egr_exp(input logic v, m, s, e);
    return {v & !s & (e | m), v & (s | !(e | m))};
  endfunction
  function automatic logic [3:0] ing_exp(input logic v, m, s, i);
    return {v & !s & (i | m), v & !s & !i & !m, !s, s};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hung handshake ends the run as a mismatch
  task automatic stall(input logic got);
    if (!got) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic got;
    n = 0;
    got = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!got && n < 100) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        got = 1;
        bready <= 0;
        resp = bresp;
      end
    end
    stall(got);
  endtask
  task automatic axi_rd(input logic [11:0] a);
    int n;
    logic got;
    n = 0;
    got = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!got && n < 100) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        got = 1;
        rready <= 0;
        rd = rdata;
        resp = rresp;
      end
    end
    stall(got);
  endtask
  // straps and power-up override are set here while reset is held
  task automatic do_reset(input logic o, p, input logic [2:0] w);
    @(posedge clk);
    rstn <= 0;
    odd <= o;
    pin <= p;
    pwo <= w;
    repeat (16) @(posedge clk);
    rstn <= 1;
    repeat (12) @(posedge clk);
  endtask
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    do_reset(0, 0, 3'h0);
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd, word(spc_pkg::SPC_CAP_4X, spc_pkg::SPC_TW_4X, 3'h0, 0, 1, 1));
    axi_wr(spc_pkg::SPC_CTL_OFFSET, word(2'h0, 3'h0, 3'h1, 0, 1, 1));
    chk(resp, spc_pkg::SPC_RESP_OKAY);
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd[26:24], spc_pkg::SPC_OVR_NONE);
    chk(n_retrain, 0);
    slow <= 1;
    axi_wr(spc_pkg::SPC_CTL_OFFSET, word(2'h0, 3'h0, spc_pkg::SPC_OVR_L0, 0, 1, 1));
    chk(ovr_w, spc_pkg::SPC_OVR_L0);
    repeat (40) @(posedge clk);
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd[29:24], {spc_pkg::SPC_TW_1X_L0, spc_pkg::SPC_OVR_L0});
    chk(ovr_w, 3'h0);
    chk(n_retrain, 1);
    slow <= 0;
    axi_wr(spc_pkg::SPC_CTL_OFFSET, word(2'h0, 3'h0, 3'h0, 0, 1, 1));
    repeat (10) @(posedge clk);
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd[29:27], spc_pkg::SPC_TW_4X);
    chk(n_retrain, 2);
    degrade <= 1;
    @(posedge clk);
    degrade <= 0;
    repeat (3) @(posedge clk);
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd[29:27], spc_pkg::SPC_TW_1X_L2);
    // every gate combination, random traffic under each
    for (int k = 0; k < 8; k++) begin
      sh = k[2];
      eg = k[1];
      ig = k[0];
      axi_wr(spc_pkg::SPC_CTL_OFFSET, word(2'h0, 3'h0, 3'h0, sh, eg, ig));
      prev = tx_in;
      repeat (12) begin
        @(posedge clk);
        r = xs();
        egr_v <= r[0];
        egr_m <= r[1];
        ing_v <= r[2];
        ing_m <= r[3];
        tx_in <= r[7:4];
        @(negedge clk);
        chk({e_iss, e_hold}, egr_exp(egr_v, egr_m, sh, eg));
        chk({i_acc, i_nac, rx_en, shut}, ing_exp(ing_v, ing_m, sh, ig));
        chk(tx, sh ? 4'h0 : prev);
        prev = tx_in;
      end
    end
    axi_rd(12'h160);
    chk(resp, spc_pkg::SPC_RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    pdown <= 1;
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd, spc_pkg::SPC_POWERDOWN_VALUE);
    pdown <= 0;
    do_reset(0, 1, spc_pkg::SPC_OVR_L2);
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd[31:30], spc_pkg::SPC_CAP_1X_ONLY);
    chk(rd[29:24], {spc_pkg::SPC_TW_4X, spc_pkg::SPC_OVR_L2});
    chk(odd_dis, 1'b1);
    pin <= 0;
    repeat (10) @(posedge clk);
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd[31:30], spc_pkg::SPC_CAP_1X_ONLY);
    do_reset(1, 0, 3'h0);
    axi_rd(spc_pkg::SPC_CTL_OFFSET);
    chk(rd[31:30], spc_pkg::SPC_CAP_1X_ONLY);
    chk(n_retrain, 2);
    conclude();
  end
  // overall bound on the run
  initial begin
    #300000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
